// >>> dv/ghp_host_if_bench.sv
// Self-checking bench for the host packet interface
module ghp_host_if_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import ghp_pkg::*;
	localparam logic [DIV_W-1:0] CPS = 32'h0000_0BB8;
	localparam logic [CFG_W-1:0] LOAD = {16'h0101, 48'h0};
	logic clock = 1'b0, sys_rst = 1'b1, rxv = 1'b0, p2v = 1'b0, ldv = 1'b1, asr = 1'b0;
	logic [7:0] rxd = 8'h00, p2d = 8'h00, rv, got_data, txd, p1c, p2c, rxc, ns, lc, lm, cd;
	logic txv, txr, got, nvs, busy, cv, da, rdy;
	logic [15:0] opt;
	logic [CFG_W-1:0] nvc, saved = '0;
	logic [7:0] expq[$];
	int fails = 0, check_count = 0, seed = 64, i;
	initial forever #20 clock = ~clock;
	ghp_host_if #(.CYC_PER_SEC(CPS)) i_ghp_host_if (.clock(clock), .sys_rst(sys_rst),
		.p1_rx_valid(rxv), .p1_rx_data(rxd), .p1_tx_valid(txv), .p1_tx_data(txd),
		.p1_tx_ready(txr), .p2_rx_valid(p2v), .p2_rx_data(p2d), .gps_time_valid(1'b1),
		.ascii_save_req(asr), .nv_load_valid(ldv), .nv_load_cfg(LOAD), .nv_save_r(nvs),
		.nv_save_cfg_r(nvc), .nv_busy_r(busy), .io_opt_r(opt), .port1_cfg_r(p1c),
		.port2_cfg_r(p2c), .rx_cfg_r(rxc), .nmea_sched_r(ns), .lp_cfg_r(lc), .lp_mode_r(lm),
		.corr_valid_r(cv), .corr_data_r(cd), .diff_active_r(da), .ready_r(rdy));
	ghp_host_model i_ghp_host_model (.clock(clock), .p1_tx_valid(txv), .p1_tx_data(txd),
		.p1_tx_ready(txr), .got(got), .got_data(got_data));
	// ==========
	// Checking
	task chk(input string n, input logic [63:0] s, input logic [63:0] e);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task test_done;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done
	// Every byte leaving port one must be the oldest note
	always @(negedge clock) begin
		if (got === 1'b1) begin
			if (expq.size() == 0) chk("stray byte", {56'h0, got_data}, 64'hFFFF);
			else chk("tx byte", got_data, expq.pop_front());
		end
	end
	always @(posedge clock) begin
		if (nvs === 1'b1) saved <= nvc;
	end
	// ==========
	// Stimulus
	// Sends a frame to port one, or notes it as an expected report
	task frame(input bit tx, input logic [7:0] id, input int n, input logic [7:0] a, b);
		logic [7:0] f[$];
		logic [7:0] pl[2];
		pl = '{a, b};
		f = {DLE, id};
		for (int k = 0; k < n; k++) begin
			f.push_back(pl[k]);
			if (pl[k] == DLE) f.push_back(DLE);
		end
		f.push_back(DLE);
		f.push_back(ETX);
		foreach (f[k]) begin
			if (tx) begin
				rxv = 1'b1;
				rxd = f[k];
				@(negedge clock);
			end else expq.push_back(f[k]);
		end
		rxv = 1'b0;
		rxd = ~rxd;
	endtask : frame
	// Bounded wait for every noted byte; a hang ends the run
	task drain;
		for (i = 0; i < 9000 && expq.size() > 0; i++) @(negedge clock);
		if (expq.size() != 0) begin
			chk("pending bytes", 64'(expq.size()), 64'h0);
			test_done;
		end
		repeat (30) @(negedge clock);
	endtask : drain
	initial begin
		frame(0, ID_TIME, 0, 8'h00, 8'h00);
		frame(0, ID_VER, 0, 8'h00, 8'h00);
		frame(0, ID_HEALTH, 0, 8'h00, 8'h00);
		frame(0, ID_STATUS, 0, 8'h00, 8'h00);
		frame(0, ID_POS_XYZ, 0, 8'h00, 8'h00);
		frame(0, ID_VEL_XYZ, 0, 8'h00, 8'h00);
		frame(0, ID_DIFF, 0, 8'h00, 8'h00);
		repeat (2) @(negedge clock);
		sys_rst = 1'b0;
		@(negedge clock);
		ldv = 1'b0;
		// A command during the power-up sequence must be dropped
		frame(1, ID_RX_CFG, 1, 8'h5A, 8'h00);
		for (i = 0; i < 2000 && rdy !== 1'b1; i++) @(negedge clock);
		chk("ready", rdy, 1'b1);
		if (rdy !== 1'b1) test_done;
		chk("early cmd", rxc, 8'h00);
		drain;
		rv = 8'($random(seed));
		frame(0, ID_OPT_REP, 2, 8'h01, 8'h10);
		frame(0, ID_PORT_CFG, 2, 8'h01, 8'h05);
		frame(0, ID_RX_CFG, 1, rv, 8'h00);
		frame(0, ID_SUPER_REP, 2, SUB_LP_CFG, rv);
		frame(0, ID_SUPER_REP, 2, SUB_LP_MODE, ~rv);
		frame(0, ID_NMEA_REP, 1, rv, 8'h00);
		// Commands go in report priority order, so queued replies keep this order
		frame(1, ID_OPT_SET, 2, 8'h01, 8'h10);
		frame(1, 8'h99, 0, 8'h00, 8'h00);
		frame(1, ID_PORT_CFG, 2, 8'h01, 8'h05);
		frame(1, ID_RX_CFG, 1, rv, 8'h00);
		frame(1, ID_SUPER_CMD, 2, SUB_LP_CFG, rv);
		frame(1, ID_SUPER_CMD, 2, SUB_LP_MODE, ~rv);
		frame(1, ID_NMEA_SET, 1, rv, 8'h00);
		drain;
		chk("options", opt, 16'h1001);
		chk("rx cfg", rxc, rv);
		chk("port cfgs", {p1c, p2c}, 16'h0005);
		chk("lp and nmea", {lc, lm, ns}, {rv, ~rv, rv});
		frame(1, ID_SUPER_CMD, 1, SUB_SAVE, 8'h00);
		repeat (4) @(negedge clock);
		chk("busy", busy, 1'b1);
		chk("saved", saved, {16'h1001, 8'h00, 8'h05, rv, rv, rv, ~rv});
		frame(1, ID_RESET, 1, FACTORY_BYTE, 8'h00);
		repeat (4) @(negedge clock);
		chk("factory", saved, FACTORY_CFG);
		chk("options", opt, OPT_DFLT);
		frame(0, ID_POS_LLA, 0, 8'h00, 8'h00);
		frame(0, ID_VEL_ENU, 0, 8'h00, 8'h00);
		drain;
		p2v = 1'b1;
		p2d = rv;
		@(negedge clock);
		p2v = 1'b0;
		p2d = ~rv;
		chk("correction", {cv, cd}, {1'b1, rv});
		// ASCII on port one is refused until the defaults command arms it
		frame(0, ID_PORT_CFG, 2, PORT1_SEL, 8'h00);
		frame(1, ID_PORT_CFG, 2, PORT1_SEL, 8'h01);
		drain;
		chk("ascii unarmed", p1c, 8'h00);
		frame(1, ID_SUPER_CMD, 1, SUB_ASCII_DEF, 8'h00);
		frame(1, ID_PORT_CFG, 2, PORT1_SEL, 8'h01);
		repeat (4) @(negedge clock);
		chk("ascii mode", p1c, 8'h01);
		asr = 1'b1;
		@(negedge clock);
		asr = 1'b0;
		repeat (2) @(negedge clock);
		chk("ascii save", saved[47:40], 8'h01);
		frame(1, ID_OPT_SET, 2, 8'h01, 8'h00);
		repeat (4) @(negedge clock);
		chk("binary ignored", opt, OPT_DFLT);
		test_done;
	end
endmodule : ghp_host_if_bench

// >>> dv/ghp_host_model.sv
// Host side model: takes report bytes off port one
module ghp_host_model (
	input wire logic clock,
	input wire logic p1_tx_valid,
	input wire logic [7:0] p1_tx_data,
	output logic p1_tx_ready,
	output logic got,
	output logic [7:0] got_data
);
	timeunit 1ns;
	timeprecision 1ns;
	int seed = 64;
	initial begin
		p1_tx_ready = 1'b0;
		got = 1'b0;
		got_data = 8'h00;
	end
	// Random stalls so the FIFO really backs up
	always @(negedge clock) begin
		p1_tx_ready <= ($random(seed) % 4) != 0;
	end
	always @(posedge clock) begin
		got <= p1_tx_valid & p1_tx_ready;
		got_data <= p1_tx_data;
	end
endmodule : ghp_host_model

// >>> verilog/ghp_deframer.sv
// Receive-side packet deframer for the first serial port
module ghp_deframer (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic in_valid,
	input wire logic [7:0] in_data,
	output logic cmd_valid,
	output logic [7:0] cmd_id,
	output logic [7:0] cmd_b0,
	output logic [7:0] cmd_b1,
	output logic [1:0] cmd_len
);
	import ghp_pkg::*;

	typedef struct packed {
		ghp_dframe_t st;
		logic [7:0] id;
		logic [1:0][7:0] b;
		logic [1:0] len;
		logic vld;
	} ghp_df_st_t;

	ghp_df_st_t r;
	ghp_df_st_t n;
	logic keep;

	// ==========================================
	// Byte walker
	always_comb begin
		n = r;
		n.vld = 1'b0;
		keep = 1'b0;
		if (in_valid) begin
			case (r.st)
				DF_HUNT: begin
					if (in_data == DLE) begin
						n.st = DF_ID;
					end
				end
				DF_ID: begin
					if (in_data == DLE || in_data == ETX) begin
						n.st = DF_HUNT;
					end else begin
						n.id = in_data;
						n.len = LEN_NONE;
						n.b = '0;
						n.st = DF_BODY;
					end
				end
				DF_BODY: begin
					if (in_data == DLE) begin
						n.st = DF_ESC;
					end else begin
						keep = 1'b1;
					end
				end
				DF_ESC: begin
					if (in_data == ETX) begin
						n.vld = 1'b1;
						n.st = DF_HUNT;
					end else if (in_data == DLE) begin
						keep = 1'b1;
						n.st = DF_BODY;
					end else begin
						// A lone escape starts a new packet, so a bad one never eats the next
						n.id = in_data;
						n.len = LEN_NONE;
						n.b = '0;
						n.st = DF_BODY;
					end
				end
				default: begin
					n.st = DF_HUNT;
				end
			endcase
		end
		// Only the first two payload bytes matter to the commands handled here
		if (keep && r.len != LEN_TWO) begin
			n.b[r.len[0]] = in_data;
			n.len = r.len + LEN_ONE;
		end
		if (sys_rst) begin
			n = '0;
		end
	end

	always_ff @(posedge clock) begin
		r <= n;
	end

	assign cmd_valid = r.vld;
	assign cmd_id = r.id;
	assign cmd_b0 = r.b[0];
	assign cmd_b1 = r.b[1];
	assign cmd_len = r.len;

endmodule : ghp_deframer

// >>> verilog/ghp_fifo.sv
// Shift-register FIFO with registered outputs on both sides
module ghp_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	import ghp_pkg::*;

	localparam int CW = $clog2(D + 1);
	localparam logic [CW-1:0] DCNT = CW'(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [CW-1:0] cnt;
		logic in_rdy;
		logic out_vld;
	} ghp_fifo_st_t;

	ghp_fifo_st_t r;
	ghp_fifo_st_t n;
	logic push;
	logic pop;
	logic [CW-1:0] wr;

	// ==========================================
	// Next state
	always_comb begin
		n = r;
		push = in_valid && r.in_rdy;
		pop = r.out_vld && out_ready;
		// Head always sits in slot zero so the output is a plain flop
		if (pop) begin
			for (int i = 0; i < D - 1; i++) begin
				n.mem[i] = r.mem[i + 1];
			end
		end
		wr = r.cnt - CW'(pop);
		if (push) begin
			n.mem[wr] = in_data;
		end
		n.cnt = r.cnt + CW'(push) - CW'(pop);
		n.in_rdy = n.cnt != DCNT;
		n.out_vld = n.cnt != '0;
		if (sys_rst) begin
			n = '0;
		end
	end

	always_ff @(posedge clock) begin
		r <= n;
	end

	assign in_ready = r.in_rdy;
	assign out_valid = r.out_vld;
	assign out_data = r.mem[0];

endmodule : ghp_fifo

// >>> verilog/ghp_host_if.sv
// Host packet interface: command decode, report scheduling and framing
// What this block does
// - Two serial ports, each configured independently
// - Port one: binary, ASCII or NMEA output
// - Port two only receives correction messages
// - Port and option settings are kept non-volatile
// - Every packet carries an identification code
// - Packets start and end with control characters
// - Position, velocity, status, health, time and differential sent automatically, settings reports on request
// - Position report every second, format from options
// - Velocity report every second, format from options
// - Status, health and time every five seconds
// - Differential mode report each second while active
// - Save command commits settings to storage
// - Saved settings govern cold start
// - ASCII mode stops binary traffic, ASCII save used
// - NMEA schedule command answered with schedule report
// - Factory reset byte restores defaults, cancels saved
// - Options command answered with options report
// - Port and receiver config answered with reports
// - Low-power commands answered with matching reports
// - Option bits choose automatic report packets
// - Power-up sequence ends in differential report
module ghp_host_if #(
	parameter logic [ghp_pkg::DIV_W-1:0] CYC_PER_SEC = ghp_pkg::CYC_PER_SEC_DFLT
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic p1_rx_valid,
	input wire logic [7:0] p1_rx_data,
	output logic p1_tx_valid,
	output logic [7:0] p1_tx_data,
	input wire logic p1_tx_ready,
	input wire logic p2_rx_valid,
	input wire logic [7:0] p2_rx_data,
	input wire logic gps_time_valid,
	input wire logic ascii_save_req,
	input wire logic nv_load_valid,
	input wire logic [ghp_pkg::CFG_W-1:0] nv_load_cfg,
	output logic nv_save_r,
	output logic [ghp_pkg::CFG_W-1:0] nv_save_cfg_r,
	output logic nv_busy_r,
	output logic [15:0] io_opt_r,
	output logic [7:0] port1_cfg_r,
	output logic [7:0] port2_cfg_r,
	output logic [7:0] rx_cfg_r,
	output logic [7:0] nmea_sched_r,
	output logic [7:0] lp_cfg_r,
	output logic [7:0] lp_mode_r,
	output logic corr_valid_r,
	output logic [7:0] corr_data_r,
	output logic diff_active_r,
	output logic ready_r
);
	import ghp_pkg::*;

	// ==========================================
	// State
	typedef struct packed {
		ghp_cfg_t cfg;
		ghp_cfg_t nv_cfg;
		logic [NUM_REP-1:0] pend;
		ghp_emit_t est;
		ghp_rep_t e_kind;
		ghp_fmt_t e_fmt;
		logic stuff;
		logic di;
		logic [DIV_W-1:0] div;
		logic [2:0] slow;
		logic [1:0] nv_hold;
		logic nv_save;
		logic nv_busy;
		logic seen;
		logic diff;
		logic ready;
		logic ascii_arm;
		logic [7:0] last_port;
		logic corr_v;
		logic [7:0] corr_d;
	} ghp_top_st_t;

	localparam ghp_top_st_t RST_ST = '{cfg: FACTORY_CFG, nv_cfg: FACTORY_CFG,
		pend: BOOT_MASK, est: EM_IDLE, e_kind: RK_TIME, default: '0};

	ghp_top_st_t r;
	ghp_top_st_t n;

	// ==========================================
	// Helpers
	function automatic logic [1:0] lang_of(input logic [7:0] pc);
		lang_of = pc[LANG_LSB +: 2];
	endfunction : lang_of

	function automatic ghp_rep_t first_set(input logic [NUM_REP-1:0] m);
		first_set = RK_TIME;
		for (int i = NUM_REP - 1; i >= 0; i--) begin
			if (m[i]) begin
				first_set = ghp_rep_t'(4'(i));
			end
		end
	endfunction : first_set

	function automatic ghp_fmt_t rep_fmt(input ghp_rep_t k, input ghp_cfg_t c,
		input logic [7:0] port);
		logic [15:0] o;
		o = c.io_opt;
		rep_fmt = '0;
		case (k)
			RK_TIME: rep_fmt.id = ID_TIME;
			RK_VER: rep_fmt.id = ID_VER;
			RK_HEALTH: rep_fmt.id = ID_HEALTH;
			RK_STATUS: rep_fmt.id = ID_STATUS;
			RK_POS: begin
				if (o[OPT_SUPER_BIT]) begin
					rep_fmt.id = ID_SUPER_REP;
					rep_fmt.sub = SUB_COMBINED;
					rep_fmt.has_sub = 1'b1;
				end else if (o[OPT_LLA_BIT]) begin
					rep_fmt.id = o[OPT_DBL_BIT] ? ID_POS_LLA_D : ID_POS_LLA;
				end else if (o[OPT_XYZ_BIT]) begin
					rep_fmt.id = o[OPT_DBL_BIT] ? ID_POS_XYZ_D : ID_POS_XYZ;
				end else begin
					rep_fmt.id = NO_ID;
				end
			end
			RK_VEL: begin
				// The combined packet already carries velocity
				if (o[OPT_SUPER_BIT]) begin
					rep_fmt.id = NO_ID;
				end else if (o[OPT_VXYZ_BIT]) begin
					rep_fmt.id = ID_VEL_XYZ;
				end else if (o[OPT_VENU_BIT]) begin
					rep_fmt.id = ID_VEL_ENU;
				end else begin
					rep_fmt.id = NO_ID;
				end
			end
			RK_DIFF: rep_fmt.id = ID_DIFF;
			RK_OPT: begin
				rep_fmt.id = ID_OPT_REP;
				rep_fmt.ndat = LEN_TWO;
				rep_fmt.dat = {o[7:0], o[15:8]};
			end
			RK_PCFG: begin
				rep_fmt.id = ID_PORT_CFG;
				rep_fmt.ndat = LEN_TWO;
				rep_fmt.dat = {port, (port == PORT1_SEL) ? c.port1_cfg : c.port2_cfg};
			end
			RK_RCFG: begin
				rep_fmt.id = ID_RX_CFG;
				rep_fmt.ndat = LEN_ONE;
				rep_fmt.dat = {c.rx_cfg, BYTE_DFLT};
			end
			RK_LPCFG, RK_LPMODE: begin
				rep_fmt.id = ID_SUPER_REP;
				rep_fmt.has_sub = 1'b1;
				rep_fmt.sub = (k == RK_LPCFG) ? SUB_LP_CFG : SUB_LP_MODE;
				rep_fmt.ndat = LEN_ONE;
				rep_fmt.dat = {(k == RK_LPCFG) ? c.lp_cfg : c.lp_mode, BYTE_DFLT};
			end
			RK_NSCHED: begin
				rep_fmt.id = ID_NMEA_REP;
				rep_fmt.ndat = LEN_ONE;
				rep_fmt.dat = {c.nmea_sched, BYTE_DFLT};
			end
			default: rep_fmt.id = NO_ID;
		endcase
	endfunction : rep_fmt

	// ==========================================
	// Receive path and transmit buffer
	logic df_in_v;
	logic cmd_v;
	logic [7:0] cmd_id;
	logic [7:0] cmd_b0;
	logic [7:0] cmd_b1;
	logic [1:0] cmd_len;
	logic emit_v;
	logic [7:0] emit_b;
	logic fifo_rdy;

	ghp_deframer u_deframer (
		.clock(clock),
		.sys_rst(sys_rst),
		.in_valid(df_in_v),
		.in_data(p1_rx_data),
		.cmd_valid(cmd_v),
		.cmd_id(cmd_id),
		.cmd_b0(cmd_b0),
		.cmd_b1(cmd_b1),
		.cmd_len(cmd_len)
	);

	ghp_fifo #(.W(FIFO_W), .D(FIFO_D)) u_tx_fifo (
		.clock(clock),
		.sys_rst(sys_rst),
		.in_valid(emit_v),
		.in_data(emit_b),
		.in_ready(fifo_rdy),
		.out_valid(p1_tx_valid),
		.out_data(p1_tx_data),
		.out_ready(p1_tx_ready)
	);

	// ==========================================
	// Next state
	logic tick;
	logic slow_tick;
	logic bin;
	logic cmd_ok;
	logic unk;
	logic save;
	logic stay;
	ghp_rep_t k;
	ghp_fmt_t f;
	logic [NUM_REP-1:0] set_m;
	logic [NUM_REP-1:0] clr_m;

	always_comb begin
		n = r;
		set_m = '0;
		clr_m = '0;
		unk = 1'b0;
		save = 1'b0;
		bin = lang_of(r.cfg.port1_cfg) == LANG_BIN;
		tick = r.div == CYC_PER_SEC - 32'h1;
		slow_tick = tick && r.slow == SLOW_TICKS - 3'h1;
		df_in_v = p1_rx_valid && bin;
		cmd_ok = cmd_v && r.ready;
		k = first_set(r.pend);
		f = rep_fmt(k, r.cfg, r.last_port);
		emit_v = r.est != EM_IDLE;
		case (r.est)
			EM_ID: emit_b = r.e_fmt.id;
			EM_SUB: emit_b = r.e_fmt.sub;
			EM_DAT: emit_b = r.di ? r.e_fmt.dat[7:0] : r.e_fmt.dat[15:8];
			EM_ETX: emit_b = ETX;
			default: emit_b = DLE;
		endcase
		stay = (r.est == EM_SUB || r.est == EM_DAT) && emit_b == DLE && !r.stuff;

		// Second and five-second timebase
		n.div = tick ? '0 : r.div + DIV_W'(1);
		if (tick) begin
			n.slow = slow_tick ? 3'h0 : r.slow + 3'h1;
		end
		if (tick && r.ready) begin
			set_m[RK_POS] = 1'b1;
			set_m[RK_VEL] = 1'b1;
			set_m[RK_DIFF] = r.diff;
		end
		if (slow_tick && r.ready) begin
			set_m[RK_STATUS] = 1'b1;
			set_m[RK_HEALTH] = 1'b1;
			set_m[RK_TIME] = 1'b1;
		end

		// Correction port: receive only, activity marks differential mode
		n.corr_v = p2_rx_valid;
		n.corr_d = p2_rx_data;
		if (tick) begin
			n.diff = r.seen;
			n.seen = 1'b0;
		end
		if (p2_rx_valid) begin
			n.seen = 1'b1;
		end

		// Stored settings are only taken before the first command window
		if (nv_load_valid && !r.ready) begin
			n.cfg = ghp_cfg_t'(nv_load_cfg);
		end
		n.nv_save = 1'b0;
		if (tick && r.nv_hold != 2'h0) begin
			n.nv_hold = r.nv_hold - 2'h1;
		end

		// Commands
		if (cmd_ok) begin
			case (cmd_id)
				ID_OPT_SET: begin
					if (cmd_len == LEN_TWO) begin
						n.cfg.io_opt = {cmd_b1, cmd_b0};
					end
					set_m[RK_OPT] = 1'b1;
				end
				ID_PORT_CFG: begin
					n.last_port = cmd_b0;
					if (cmd_len == LEN_TWO) begin
						if (cmd_b0 != PORT1_SEL) begin
							n.cfg.port2_cfg = cmd_b1;
						end else if (lang_of(cmd_b1) != LANG_ASCII || r.ascii_arm) begin
							n.cfg.port1_cfg = cmd_b1;
						end
					end
					set_m[RK_PCFG] = 1'b1;
				end
				ID_RX_CFG: begin
					if (cmd_len != LEN_NONE) begin
						n.cfg.rx_cfg = cmd_b0;
					end
					set_m[RK_RCFG] = 1'b1;
				end
				ID_NMEA_SET: begin
					if (cmd_len != LEN_NONE) begin
						n.cfg.nmea_sched = cmd_b0;
					end
					set_m[RK_NSCHED] = 1'b1;
				end
				ID_RESET: begin
					if (cmd_len != LEN_NONE && cmd_b0 == FACTORY_BYTE) begin
						n.cfg = FACTORY_CFG;
						save = 1'b1;
					end
				end
				ID_SUPER_CMD: begin
					case (cmd_b0)
						SUB_SAVE: save = 1'b1;
						SUB_ASCII_DEF: n.ascii_arm = 1'b1;
						SUB_LP_CFG: begin
							if (cmd_len == LEN_TWO) begin
								n.cfg.lp_cfg = cmd_b1;
							end
							set_m[RK_LPCFG] = 1'b1;
						end
						SUB_LP_MODE: begin
							if (cmd_len == LEN_TWO) begin
								n.cfg.lp_mode = cmd_b1;
							end
							set_m[RK_LPMODE] = 1'b1;
						end
						default: unk = 1'b1;
					endcase
				end
				default: unk = 1'b1;
			endcase
		end
		if (ascii_save_req && lang_of(r.cfg.port1_cfg) == LANG_ASCII) begin
			save = 1'b1;
		end
		if (save) begin
			n.nv_save = 1'b1;
			n.nv_cfg = n.cfg;
			n.nv_hold = NV_HOLD_TICKS;
		end
		// Registered so the busy output needs no decode after the flop
		n.nv_busy = n.nv_hold != 2'h0;

		// Report emitter
		case (r.est)
			EM_IDLE: begin
				if (r.pend != '0) begin
					clr_m[k] = 1'b1;
					// No time report until the clock is known
					if (f.id != NO_ID && (k != RK_TIME || gps_time_valid)) begin
						n.e_kind = k;
						n.e_fmt = f;
						n.di = 1'b0;
						n.est = EM_LEAD;
					end
				end
			end
			EM_LEAD: if (fifo_rdy) n.est = EM_ID;
			EM_ID: begin
				if (fifo_rdy) begin
					n.est = r.e_fmt.has_sub ? EM_SUB :
						(r.e_fmt.ndat != LEN_NONE) ? EM_DAT : EM_TRAIL;
				end
			end
			EM_SUB, EM_DAT: begin
				if (fifo_rdy) begin
					n.stuff = stay;
					if (!stay && r.est == EM_SUB) begin
						n.est = (r.e_fmt.ndat != LEN_NONE) ? EM_DAT : EM_TRAIL;
					end else if (!stay) begin
						n.di = 1'b1;
						if (r.di || r.e_fmt.ndat == LEN_ONE) begin
							n.est = EM_TRAIL;
						end
					end
				end
			end
			EM_TRAIL: if (fifo_rdy) n.est = EM_ETX;
			EM_ETX: begin
				if (fifo_rdy) begin
					n.est = EM_IDLE;
					if (r.e_kind == RK_DIFF) begin
						n.ready = 1'b1;
					end
				end
			end
			default: n.est = EM_IDLE;
		endcase
		n.pend = (r.pend & ~clr_m) | set_m;
		if (!bin) begin
			n.est = EM_IDLE;
			n.pend = '0;
			n.ready = 1'b1;
		end
		if (sys_rst) begin
			n = RST_ST;
		end
	end

	always_ff @(posedge clock) begin
		r <= n;
	end

	assign nv_save_r = r.nv_save;
	assign nv_save_cfg_r = r.nv_cfg;
	assign nv_busy_r = r.nv_busy;
	assign io_opt_r = r.cfg.io_opt;
	assign port1_cfg_r = r.cfg.port1_cfg;
	assign port2_cfg_r = r.cfg.port2_cfg;
	assign rx_cfg_r = r.cfg.rx_cfg;
	assign nmea_sched_r = r.cfg.nmea_sched;
	assign lp_cfg_r = r.cfg.lp_cfg;
	assign lp_mode_r = r.cfg.lp_mode;
	assign corr_valid_r = r.corr_v;
	assign corr_data_r = r.corr_d;
	assign diff_active_r = r.diff;
	assign ready_r = r.ready;

	// ==========================================
	// Checks
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	a_boot_ends_diff: assert property ($rose(r.ready) && bin |-> $past(r.e_kind == RK_DIFF))
		else $error("ready without differential report");
	a_early_cmd_drop: assert property (cmd_v && !r.ready && !nv_load_valid |=> $stable(r.cfg))
		else $error("command taken before power-up sequence ended");
	a_opt_answer: assert property (cmd_ok && cmd_id == ID_OPT_SET |=> r.pend[RK_OPT])
		else $error("options command not answered");
	a_port_answer: assert property (cmd_ok && cmd_id == ID_PORT_CFG |=> r.pend[RK_PCFG] || !bin)
		else $error("port config not answered");
	a_factory_load: assert property (cmd_ok && cmd_id == ID_RESET && cmd_b0 == FACTORY_BYTE
		&& cmd_len != LEN_NONE |=> r.cfg == FACTORY_CFG && r.nv_save ##1 !r.nv_save)
		else $error("factory restore missing");
	a_save_copy: assert property (cmd_ok && cmd_id == ID_SUPER_CMD && cmd_b0 == SUB_SAVE
		|=> r.nv_save && r.nv_cfg == $past(r.cfg) && nv_busy_r)
		else $error("save did not commit settings");
	a_ascii_silent: assert property (!bin |=> r.est == EM_IDLE && r.pend == '0)
		else $error("binary traffic outside binary mode");
	a_pos_second: assert property (tick && r.ready && bin |=> r.pend[RK_POS] || !bin)
		else $error("position report not scheduled");
	a_status_slow: assert property (slow_tick && r.ready && bin
		|=> (r.pend[RK_STATUS] && r.pend[RK_HEALTH]) || !bin)
		else $error("status and health not scheduled");
	a_diff_second: assert property (tick && r.ready && r.diff && bin |=> r.pend[RK_DIFF] || !bin)
		else $error("differential report not scheduled");
	a_unknown_drop: assert property (cmd_ok && unk |=> $stable(r.cfg) && !r.nv_save)
		else $error("unknown command changed state");

	c_boot_done: cover property ($rose(r.ready));
	c_factory: cover property (cmd_ok && cmd_id == ID_RESET);
	c_ascii_mode: cover property ($fell(bin));
	c_fifo_full: cover property (emit_v && !fifo_rdy);

endmodule : ghp_host_if

// >>> verilog/ghp_pkg.sv
// Shared constants and types for the host packet interface
package ghp_pkg;

	// ==========================================
	// Timing
	localparam int CLK_HZ = 25_000_000;
	localparam int FAST_PERIOD_S = 1;
	localparam int SLOW_PERIOD_S = 5;
	localparam int NV_HOLD_S = 2;
	localparam int DIV_W = 32;
	localparam logic [DIV_W-1:0] CYC_PER_SEC_DFLT = DIV_W'(CLK_HZ * FAST_PERIOD_S);
	localparam logic [2:0] SLOW_TICKS = 3'(SLOW_PERIOD_S / FAST_PERIOD_S);
	localparam logic [1:0] NV_HOLD_TICKS = 2'(NV_HOLD_S / FAST_PERIOD_S);

	// ==========================================
	// Framing and payload lengths
	localparam logic [7:0] DLE = 8'h10;
	localparam logic [7:0] ETX = 8'h03;
	localparam logic [1:0] LEN_NONE = 2'h0;
	localparam logic [1:0] LEN_ONE = 2'h1;
	localparam logic [1:0] LEN_TWO = 2'h2;

	// ==========================================
	// Packet identification codes
	localparam logic [7:0] ID_TIME = 8'h41;
	localparam logic [7:0] ID_VER = 8'h45;
	localparam logic [7:0] ID_HEALTH = 8'h46;
	localparam logic [7:0] ID_STATUS = 8'h4B;
	localparam logic [7:0] ID_POS_XYZ = 8'h42;
	localparam logic [7:0] ID_POS_XYZ_D = 8'h83;
	localparam logic [7:0] ID_POS_LLA = 8'h4A;
	localparam logic [7:0] ID_POS_LLA_D = 8'h84;
	localparam logic [7:0] ID_VEL_XYZ = 8'h43;
	localparam logic [7:0] ID_VEL_ENU = 8'h56;
	localparam logic [7:0] ID_DIFF = 8'h82;
	localparam logic [7:0] ID_SUPER_REP = 8'h8F;
	localparam logic [7:0] ID_SUPER_CMD = 8'h8E;
	localparam logic [7:0] SUB_COMBINED = 8'h20;
	localparam logic [7:0] SUB_SAVE = 8'h26;
	localparam logic [7:0] SUB_LP_CFG = 8'h27;
	localparam logic [7:0] SUB_LP_MODE = 8'h25;
	localparam logic [7:0] SUB_ASCII_DEF = 8'h40;
	localparam logic [7:0] ID_OPT_SET = 8'h35;
	localparam logic [7:0] ID_OPT_REP = 8'h55;
	localparam logic [7:0] ID_PORT_CFG = 8'hBC;
	localparam logic [7:0] ID_RX_CFG = 8'hBB;
	localparam logic [7:0] ID_NMEA_SET = 8'h7A;
	localparam logic [7:0] ID_NMEA_REP = 8'h7B;
	localparam logic [7:0] ID_RESET = 8'h1E;
	localparam logic [7:0] FACTORY_BYTE = 8'h46;
	localparam logic [7:0] NO_ID = 8'h00;

	// ==========================================
	// Option bits and port configuration fields
	localparam int OPT_XYZ_BIT = 0;
	localparam int OPT_LLA_BIT = 1;
	localparam int OPT_DBL_BIT = 4;
	localparam int OPT_SUPER_BIT = 5;
	localparam int OPT_VXYZ_BIT = 8;
	localparam int OPT_VENU_BIT = 9;
	localparam logic [15:0] OPT_DFLT = 16'h0202;
	localparam int LANG_LSB = 0;
	localparam logic [1:0] LANG_BIN = 2'h0;
	localparam logic [1:0] LANG_ASCII = 2'h1;
	localparam logic [1:0] LANG_NMEA = 2'h2;
	localparam logic [7:0] PORT1_SEL = 8'h00;
	localparam logic [7:0] PORT_DFLT = 8'h00;
	localparam logic [7:0] BYTE_DFLT = 8'h00;

	typedef struct packed {
		logic [15:0] io_opt;
		logic [7:0] port1_cfg;
		logic [7:0] port2_cfg;
		logic [7:0] rx_cfg;
		logic [7:0] nmea_sched;
		logic [7:0] lp_cfg;
		logic [7:0] lp_mode;
	} ghp_cfg_t;
	localparam int CFG_W = $bits(ghp_cfg_t);
	localparam ghp_cfg_t FACTORY_CFG = '{OPT_DFLT, PORT_DFLT, PORT_DFLT,
		BYTE_DFLT, BYTE_DFLT, BYTE_DFLT, BYTE_DFLT};

	// ==========================================
	// Report kinds, in power-up emission order
	typedef enum logic [3:0] {
		RK_TIME, RK_VER, RK_HEALTH, RK_STATUS, RK_POS, RK_VEL, RK_DIFF,
		RK_OPT, RK_PCFG, RK_RCFG, RK_LPCFG, RK_LPMODE, RK_NSCHED
	} ghp_rep_t;
	localparam int NUM_REP = 13;
	localparam logic [NUM_REP-1:0] BOOT_MASK = 13'h007F;

	typedef struct packed {
		logic [7:0] id;
		logic [7:0] sub;
		logic has_sub;
		logic [1:0] ndat;
		logic [15:0] dat;
	} ghp_fmt_t;

	// ==========================================
	// State machines
	typedef enum logic [2:0] {
		EM_IDLE = 3'h0, EM_LEAD = 3'h1, EM_ID = 3'h3, EM_SUB = 3'h2,
		EM_DAT = 3'h6, EM_TRAIL = 3'h7, EM_ETX = 3'h5
	} ghp_emit_t;
	typedef enum logic [1:0] {
		DF_HUNT = 2'h0, DF_ID = 2'h1, DF_BODY = 2'h3, DF_ESC = 2'h2
	} ghp_dframe_t;

	localparam int FIFO_W = 8;
	localparam int FIFO_D = 8;

endpackage : ghp_pkg
